// >>> upc_params.svh
// register offsets, widths, reset values and field positions of the map tail
// assumes: included by the register bank, definitions only
`ifndef UPC_PARAMS_SVH
`define UPC_PARAMS_SVH

`define UPC_ADDR_LAST 5'h19
`define UPC_ADDR_PROFILE_SEVEN 5'h15
`define UPC_ADDR_RAM_ACCESS 5'h16
`define UPC_ADDR_GPIO_DIR 5'h18
`define UPC_ADDR_GPIO_VAL 5'h19
`define UPC_ADDR_UNUSED_A 5'h07
`define UPC_ADDR_UNUSED_B 5'h08
`define UPC_ADDR_UNUSED_C_LO 5'h0B
`define UPC_ADDR_UNUSED_C_HI 5'h0D
`define UPC_ADDR_UNUSED_D 5'h17

`define UPC_BYTES_PROFILE_SEVEN 4'h8
`define UPC_BYTES_RAM_ACCESS 4'h4
`define UPC_BYTES_GPIO 4'h2
`define UPC_BYTES_NONE 4'h0

`define UPC_RESET_PROFILE_SEVEN 64'h0000_0000_0000_0000
`define UPC_RESET_RAM_ACCESS 32'h0000_0000
`define UPC_RESET_GPIO 16'h0000

`define UPC_FTW_LSB 0
`define UPC_FTW_MSB 31
`define UPC_PHASE_LSB 32
`define UPC_PHASE_MSB 47
`define UPC_AMP_LSB 48
`define UPC_AMP_MSB 61
`define UPC_OSF_LSB 48
`define UPC_OSF_MSB 55
`define UPC_BYPASS_BIT 56
`define UPC_INVERT_BIT 57
`define UPC_RATE_LSB 58
`define UPC_RATE_MSB 63

`define UPC_MODE_QUAD 2'b00
`define UPC_MODE_TONE 2'b01

`endif

// >>> upc_pkg.sv
// types shared by the register bank of the upconverter map tail
// assumes: upc_params.svh alongside
package upc_pkg;
	typedef enum logic [1:0] {
		UPC_QUAD,
		UPC_TONE,
		UPC_INTERP
	} upc_mode_t;

	typedef struct packed {
		logic [31:0] tuningWord;
		logic [15:0] phaseOffset;
		logic [13:0] amplitudeScale;
	} upc_tone_t;

	typedef struct packed {
		logic [5:0] interpRateHigh;
		logic spectralInvert;
		logic inverseFilterBypass;
		logic [7:0] outputScale;
		logic [15:0] phaseOffset;
		logic [31:0] tuningWord;
	} upc_quad_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [4:0] addr;
		logic [63:0] data;
	} upc_access_t;
endpackage : upc_pkg

// >>> upc_register_bank.sv
// register bank for profile seven, ram access word and gpio registers
// assumes: serial port logic on the same clock presents decoded accesses;
// update strobe and profile pins arrive asynchronously from outside
`include "upc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module upc_register_bank
	import upc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire upc_access_t access,
	input wire logic [1:0] operatingMode,
	input wire logic updatePin,
	input wire logic [2:0] profilePins,
	output logic [63:0] readData,
	output logic [3:0] byteCount,
	output logic addrInRange,
	output logic addrOwned,
	output upc_mode_t activeMode,
	output upc_tone_t toneFields,
	output upc_quad_t quadFields,
	output logic [31:0] ramWord,
	output logic [15:0] gpioDirection,
	output logic [15:0] gpioValues
);
	logic resetSync1, resetSync2;
	logic [3:0] pinSync1, pinSync2, pinSync3, pinFiltered, next_pinFiltered;
	logic [63:0] bufProfile, next_bufProfile, actProfile, next_actProfile;
	logic [31:0] bufRam, next_bufRam, next_ramWord;
	logic [15:0] bufGpioDir, next_bufGpioDir, bufGpioVal, next_bufGpioVal;
	logic [15:0] next_gpioDirection, next_gpioValues;
	logic [63:0] next_readData;
	logic [3:0] next_byteCount;
	logic next_addrInRange, next_addrOwned, unusedSlot, transfer;
	upc_mode_t next_activeMode;
	upc_tone_t next_toneFields;
	upc_quad_t next_quadFields;

	// reset release
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			resetSync1 <= 1'b0;
			resetSync2 <= 1'b0;
		end else begin
			resetSync1 <= 1'b1;
			resetSync2 <= resetSync1;
		end
	end

	// pin filter: a change counts once stages two and three agree
	always_comb begin
		next_pinFiltered = pinFiltered;
		if (pinSync2 == pinSync3) begin
			next_pinFiltered = pinSync3;
		end
	end

	always_ff @(posedge clock or negedge resetSync2) begin
		if (!resetSync2) begin
			pinSync1 <= 4'h0;
			pinSync2 <= 4'h0;
			pinSync3 <= 4'h0;
			pinFiltered <= 4'h0;
		end else begin
			pinSync1 <= {updatePin, profilePins};
			pinSync2 <= pinSync1;
			pinSync3 <= pinSync2;
			pinFiltered <= next_pinFiltered;
		end
	end

	// update rising edge or profile change
	assign transfer = (next_pinFiltered[3] && !pinFiltered[3]) ||
		(next_pinFiltered[2:0] != pinFiltered[2:0]);

	assign unusedSlot = (access.addr == `UPC_ADDR_UNUSED_A) || (access.addr == `UPC_ADDR_UNUSED_B) ||
		((access.addr >= `UPC_ADDR_UNUSED_C_LO) && (access.addr <= `UPC_ADDR_UNUSED_C_HI)) ||
		(access.addr == `UPC_ADDR_UNUSED_D);

	always_comb begin
		next_bufProfile = bufProfile;
		next_bufRam = bufRam;
		next_bufGpioDir = bufGpioDir;
		next_bufGpioVal = bufGpioVal;
		next_actProfile = actProfile;
		next_ramWord = ramWord;
		next_gpioDirection = gpioDirection;
		next_gpioValues = gpioValues;
		next_readData = readData;
		next_byteCount = byteCount;
		next_addrInRange = addrInRange;
		next_addrOwned = addrOwned;
		if (access.valid) begin
			next_addrInRange = (access.addr <= `UPC_ADDR_LAST);
			next_addrOwned = 1'b0;
			next_readData = 64'h0000_0000_0000_0000;
			next_byteCount = `UPC_BYTES_NONE;
			// holes and foreign slots answer zero
			if (!unusedSlot) begin
				case (access.addr)
					`UPC_ADDR_PROFILE_SEVEN: begin
						next_addrOwned = 1'b1;
						next_byteCount = `UPC_BYTES_PROFILE_SEVEN;
						next_readData = bufProfile;
						if (access.write) begin
							next_bufProfile = access.data;
						end
					end
					`UPC_ADDR_RAM_ACCESS: begin
						next_addrOwned = 1'b1;
						next_byteCount = `UPC_BYTES_RAM_ACCESS;
						next_readData = {32'h0000_0000, bufRam};
						if (access.write) begin
							next_bufRam = access.data[31:0];
						end
					end
					`UPC_ADDR_GPIO_DIR: begin
						next_addrOwned = 1'b1;
						next_byteCount = `UPC_BYTES_GPIO;
						next_readData = {48'h0000_0000_0000, bufGpioDir};
						if (access.write) begin
							next_bufGpioDir = access.data[15:0];
						end
					end
					`UPC_ADDR_GPIO_VAL: begin
						next_addrOwned = 1'b1;
						next_byteCount = `UPC_BYTES_GPIO;
						next_readData = {48'h0000_0000_0000, bufGpioVal};
						if (access.write) begin
							next_bufGpioVal = access.data[15:0];
						end
					end
					default: begin
						next_addrOwned = 1'b0;
					end
				endcase
			end
		end
		// buffered copy moves to the active side
		// a write in the transfer cycle is not yet seen; it waits for the next strobe
		if (transfer) begin
			next_actProfile = bufProfile;
			next_ramWord = bufRam;
			next_gpioDirection = bufGpioDir;
			next_gpioValues = bufGpioVal;
		end
	end

	always_comb begin
		case (operatingMode)
			`UPC_MODE_QUAD: next_activeMode = UPC_QUAD;
			`UPC_MODE_TONE: next_activeMode = UPC_TONE;
			default: next_activeMode = UPC_INTERP;
		endcase
	end

	// fields taken as whole binary words
	always_comb begin
		next_toneFields.tuningWord = actProfile[`UPC_FTW_MSB:`UPC_FTW_LSB];
		next_toneFields.phaseOffset = actProfile[`UPC_PHASE_MSB:`UPC_PHASE_LSB];
		next_toneFields.amplitudeScale = actProfile[`UPC_AMP_MSB:`UPC_AMP_LSB];
	end

	always_comb begin
		next_quadFields.interpRateHigh = actProfile[`UPC_RATE_MSB:`UPC_RATE_LSB];
		next_quadFields.spectralInvert = actProfile[`UPC_INVERT_BIT];
		next_quadFields.inverseFilterBypass = actProfile[`UPC_BYPASS_BIT];
		next_quadFields.outputScale = actProfile[`UPC_OSF_MSB:`UPC_OSF_LSB];
		next_quadFields.phaseOffset = actProfile[`UPC_PHASE_MSB:`UPC_PHASE_LSB];
		next_quadFields.tuningWord = actProfile[`UPC_FTW_MSB:`UPC_FTW_LSB];
	end

	always_ff @(posedge clock or negedge resetSync2) begin
		if (!resetSync2) begin
			bufProfile <= `UPC_RESET_PROFILE_SEVEN;
			bufRam <= `UPC_RESET_RAM_ACCESS;
			bufGpioDir <= `UPC_RESET_GPIO;
			bufGpioVal <= `UPC_RESET_GPIO;
			actProfile <= `UPC_RESET_PROFILE_SEVEN;
			ramWord <= `UPC_RESET_RAM_ACCESS;
			gpioDirection <= `UPC_RESET_GPIO;
			gpioValues <= `UPC_RESET_GPIO;
			readData <= 64'h0000_0000_0000_0000;
			byteCount <= `UPC_BYTES_NONE;
			addrInRange <= 1'b0;
			addrOwned <= 1'b0;
			activeMode <= UPC_QUAD;
			toneFields <= '0;
			quadFields <= '0;
		end else begin
			bufProfile <= next_bufProfile;
			bufRam <= next_bufRam;
			bufGpioDir <= next_bufGpioDir;
			bufGpioVal <= next_bufGpioVal;
			actProfile <= next_actProfile;
			ramWord <= next_ramWord;
			gpioDirection <= next_gpioDirection;
			gpioValues <= next_gpioValues;
			readData <= next_readData;
			byteCount <= next_byteCount;
			addrInRange <= next_addrInRange;
			addrOwned <= next_addrOwned;
			activeMode <= next_activeMode;
			toneFields <= next_toneFields;
			quadFields <= next_quadFields;
		end
	end
endmodule : upc_register_bank

`default_nettype wire

// >>> upc_bank_props.sv
// checker for the map tail register bank
// assumes: bound to upc_register_bank, one clock domain
`timescale 1ns/1ps
`default_nettype none
module upc_bank_props
	import upc_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire upc_access_t access,
	input wire logic [1:0] operatingMode,
	input wire logic updatePin,
	input wire logic [2:0] profilePins,
	input wire logic [63:0] readData,
	input wire logic [3:0] byteCount,
	input wire logic addrInRange,
	input wire logic addrOwned,
	input wire upc_mode_t activeMode,
	input wire upc_tone_t toneFields,
	input wire upc_quad_t quadFields,
	input wire logic [31:0] ramWord,
	input wire logic [15:0] gpioDirection,
	input wire logic [15:0] gpioValues
);
	logic [3:0] quiet;
	logic [3:0] next_quiet;
	logic [3:0] lastPins;
	logic [1:0] lastMode;
	// cycles since any pin moved, saturating
	always_comb begin
		next_quiet = (quiet == 4'hf) ? quiet : quiet + 4'h1;
		if ({updatePin, profilePins} != lastPins) next_quiet = 4'h0;
	end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			quiet <= 4'h0;
			lastPins <= 4'h0;
			lastMode <= 2'b00;
		end else begin
			quiet <= next_quiet;
			lastPins <= {updatePin, profilePins};
			lastMode <= operatingMode;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	range_flag_a:
	assert property (access.valid |=> addrInRange == ($past(access.addr) <= 5'h19)) else $error("range flag wrong");
	hole_reads_zero_a:
	assert property (access.valid && (access.addr inside {5'h07, 5'h08, [5'h0b:5'h0d], 5'h17})
		|=> readData == 64'h0 && byteCount == 4'h0 && !addrOwned) else $error("hole not empty");
	profile_bytes_a:
	assert property (access.valid && access.addr == 5'h15 |=> byteCount == 4'h8 && addrOwned) else $error("profile size");
	word_bytes_a:
	assert property (access.valid && access.addr == 5'h16 |=> byteCount == 4'h4) else $error("ram word size");
	gpio_bytes_a:
	assert property (access.valid && access.addr[4:1] == 4'hc |=> byteCount == 4'h2) else $error("gpio size");
	buffer_holds_a:
	assert property (quiet > 4'h7 |-> $stable(ramWord) && $stable(gpioValues) && $stable(gpioDirection)
		&& $stable(toneFields)) else $error("active value moved without transfer");
	field_split_a:
	assert property (toneFields == {quadFields.tuningWord, quadFields.phaseOffset, quadFields.interpRateHigh[3:0],
		quadFields.spectralInvert, quadFields.inverseFilterBypass, quadFields.outputScale}) else $error("field split");
	mode_follow_a:
	assert property ($past(reset_n, 3) |-> activeMode == (lastMode[1] ? UPC_INTERP : lastMode[0] ? UPC_TONE : UPC_QUAD))
		else $error("mode decode");
endmodule : upc_bank_props
bind upc_register_bank upc_bank_props upc_bank_props_i (.clock(clock), .reset_n(reset_n), .access(access),
	.operatingMode(operatingMode), .updatePin(updatePin), .profilePins(profilePins), .readData(readData),
	.byteCount(byteCount), .addrInRange(addrInRange), .addrOwned(addrOwned), .activeMode(activeMode),
	.toneFields(toneFields), .quadFields(quadFields), .ramWord(ramWord), .gpioDirection(gpioDirection),
	.gpioValues(gpioValues));
`default_nettype wire

// >>> upc_host.sv
// host model presenting decoded serial accesses
// assumes: bank samples on the rising edge
`timescale 1ns/1ps
`default_nettype none
module upc_host
	import upc_pkg::*;
(
	input wire logic clock,
	output var upc_access_t access
);
	initial access = '0;
	task automatic xfer(input logic w, input logic [4:0] a, input logic [63:0] d);
		@(negedge clock);
		access = '{valid: 1'b1, write: w, addr: a, data: d};
		@(negedge clock);
		// idle data flipped so nothing leans on stale bits
		access = '{valid: 1'b0, write: w, addr: a, data: ~d};
	endtask : xfer
endmodule : upc_host
`default_nettype wire

// >>> upconverter_register_map_tail_tb.sv
// testbench for the map tail register bank
// assumes: host model drives the access port
`timescale 1ns/1ps
`default_nettype none
module upconverter_register_map_tail_tb;
	import upc_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] operatingMode = 2'b00;
	logic updatePin = 1'b0;
	logic [2:0] profilePins = 3'b000;
	upc_access_t access;
	logic [63:0] readData;
	logic [3:0] byteCount;
	logic addrInRange, addrOwned;
	upc_mode_t activeMode;
	upc_tone_t toneFields;
	upc_quad_t quadFields;
	logic [31:0] ramWord;
	logic [15:0] gpioDirection, gpioValues;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [4:0] holes [6] = '{5'h07, 5'h08, 5'h0b, 5'h0c, 5'h0d, 5'h17};
	localparam logic [63:0] P = 64'hc5a3_1234_89ab_cdef;
	always #20 clock = ~clock;
	upc_register_bank upc_register_bank_i (.clock(clock), .reset_n(reset_n), .access(access),
		.operatingMode(operatingMode), .updatePin(updatePin), .profilePins(profilePins), .readData(readData),
		.byteCount(byteCount), .addrInRange(addrInRange), .addrOwned(addrOwned), .activeMode(activeMode),
		.toneFields(toneFields), .quadFields(quadFields), .ramWord(ramWord), .gpioDirection(gpioDirection),
		.gpioValues(gpioValues));
	upc_host upc_host_i (.clock(clock), .access(access));
	task automatic wrap_up();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic rd(input logic [4:0] a, input logic [63:0] exp, input logic [3:0] n);
		upc_host_i.xfer(1'b0, a, 64'h0);
		chk("readData", readData, exp);
		chk("byteCount", {60'h0, byteCount}, {60'h0, n});
		chk("addrOwned", {63'h0, addrOwned}, {63'h0, n != 4'h0});
	endtask : rd
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	initial begin
		repeat (8) @(negedge clock);
		reset_n = 1'b1;
		repeat (4) @(negedge clock);
		chk("toneFields", {2'b00, toneFields}, 64'h0);
		rd(5'h15, 64'h0, 4'h8);
		rd(5'h19, 64'h0, 4'h2);
		upc_host_i.xfer(1'b1, 5'h15, P);
		upc_host_i.xfer(1'b1, 5'h16, 64'hffff_ffff_0bad_f00d);
		upc_host_i.xfer(1'b1, 5'h18, 64'h7777_0000_1234_a5c3);
		upc_host_i.xfer(1'b1, 5'h19, 64'h0000_0000_0000_5a3c);
		// holes and foreign slots swallow writes
		foreach (holes[i]) begin
			upc_host_i.xfer(1'b1, holes[i], '1);
			rd(holes[i], 64'h0, 4'h0);
		end
		upc_host_i.xfer(1'b1, 5'h1a, '1);
		chk("addrInRange", {63'h0, addrInRange}, 64'h0);
		rd(5'h00, 64'h0, 4'h0);
		chk("addrInRange", {63'h0, addrInRange}, 64'h1);
		chk("ramWord", {32'h0, ramWord}, 64'h0);
		rd(5'h15, P, 4'h8);
		rd(5'h16, 64'h0bad_f00d, 4'h4);
		rd(5'h18, 64'ha5c3, 4'h2);
		@(negedge clock);
		updatePin = 1'b1;
		repeat (4) @(negedge clock);
		updatePin = 1'b0;
		repeat (6) @(negedge clock);
		chk("toneFields", {2'b00, toneFields}, {2'b00, P[31:0], P[47:32], P[61:48]});
		chk("quadFields", quadFields, P);
		chk("ramWord", {32'h0, ramWord}, 64'h0bad_f00d);
		chk("gpio", {32'h0, gpioDirection, gpioValues}, 64'ha5c3_5a3c);
		upc_host_i.xfer(1'b1, 5'h16, 64'h1357_2468);
		chk("ramWord", {32'h0, ramWord}, 64'h0bad_f00d);
		profilePins = 3'b101;
		repeat (7) @(negedge clock);
		chk("ramWord", {32'h0, ramWord}, 64'h1357_2468);
		for (int m = 0; m < 4; m++) begin
			operatingMode = m[1:0];
			repeat (2) @(negedge clock);
			chk("activeMode", {62'h0, activeMode}, m > 1 ? UPC_INTERP : m == 1 ? UPC_TONE : UPC_QUAD);
		end
		wrap_up();
	end
endmodule : upconverter_register_map_tail_tb
`default_nettype wire
